// File: rtl/msb_pkg.sv
// shared constants and types for the modem sideband pin block
package msb_pkg;
  // clock of the block and the crystal that the modem clock output is divided from
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned XTAL_HZ = 16_000_000;
  // phase accumulator width of the clock output synthesiser
  localparam int unsigned ACC_W = 24;
  // stages of every pin synchroniser
  localparam int unsigned SYNC_STAGES = 2;
  // clock output frequency select codes
  localparam logic [2:0] SEL_16M = 3'h0;
  localparam logic [2:0] SEL_8M = 3'h1;
  localparam logic [2:0] SEL_4M = 3'h2;
  localparam logic [2:0] SEL_2M = 3'h3;
  localparam logic [2:0] SEL_1M = 3'h4;
  localparam logic [2:0] SEL_62K5 = 3'h5;
  localparam logic [2:0] SEL_32K786 = 3'h6;
  localparam logic [2:0] SEL_16K393 = 3'h7;
  // value of the frequency select after reset
  localparam logic [2:0] CLK_SEL_RST = SEL_32K786;
  // crystal divisor for each select code, index = code
  localparam int unsigned MODEM_CLOCK_OUT_DIV [0:7] = '{1, 2, 4, 8, 16, 256, 488, 976};
  // operating modes of the modem
  typedef enum logic [2:0] {
    ST_OFF,
    ST_IDLE,
    ST_DOZE,
    ST_HIBER,
    ST_ACTIVE
  } msb_mode_t;
endpackage : msb_pkg

// File: rtl/msb_clk_if.sv
// carrier between the sideband top and the clock output synthesiser
interface msb_clk_if;
  logic [2:0] sel;
  logic run;
  logic clk_out;
  modport ctl (output sel, output run, input clk_out);
  modport gen (input sel, input run, output clk_out);
endinterface : msb_clk_if

// File: rtl/msb_clkgen.sv
// programmable modem clock output synthesiser (phase accumulator)
module msb_clkgen #(
  parameter int unsigned ACC_W = msb_pkg::ACC_W
) (
  input wire logic clk,
  input wire logic rstn,
  msb_clk_if.gen cif
);

  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic out;
  } msb_gen_state_t;

  msb_gen_state_t s_q;
  msb_gen_state_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  // increment = 2^ACC_W * f_out / f_clk; 16 MHz from 40 MHz is not an integer
  // ratio, so the 16 MHz setting carries cycle jitter but holds the mean frequency
  function automatic logic [ACC_W-1:0] modem_clock_out_inc(input logic [2:0] sel);
    longint t;
    t = ((longint'(1) << ACC_W) * longint'(msb_pkg::XTAL_HZ)) /
        (longint'(msb_pkg::MODEM_CLOCK_OUT_DIV[sel]) * longint'(msb_pkg::CLK_HZ));
    return t[ACC_W-1:0];
  endfunction : modem_clock_out_inc

  // accumulate while running, park low when stopped
  always_comb begin
    s_d = s_q;
    if (cif.run) begin
      s_d.acc = s_q.acc + modem_clock_out_inc(cif.sel); // RULE1
    end else begin
      s_d.acc = '0;
    end
    s_d.out = s_d.acc[ACC_W-1];
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign cif.clk_out = s_q.out;

  chk_clk_stopped: assert property (@(posedge clk) disable iff (!rstn) // RULE15
    !cif.run |=> !cif.clk_out) else $error("clock output not parked low when stopped");

endmodule : msb_clkgen

// File: rtl/msb_sideband.sv
// modem sideband pins: mode control, clock output, indicators, data-out, interrupt
// Summary of operation
// RULE1 - clock output selectable, 32.786 kHz after reset
// RULE2 - alternate mode drives pin 2 as CRC-valid
// RULE3 - alternate mode drives pin 1 as out-of-idle
// RULE4 - general pins are inputs after reset
// RULE5 - host programs unused pins as low outputs
// RULE6 - attention low wakes hibernate or doze
// RULE7 - host keeps inputs driven in low power
// RULE8 - data-out tri-state when deselected, else low
// RULE9 - host drives radio enable to start sequences
// RULE10 - host drives the modem reset input
// RULE11 - interrupt requests on dedicated interrupt output
// RULE12 - host is serial master, modem slave
// RULE13 - read data returned on data-out line
// RULE14 - serial clock at most 8 MHz, select low
// RULE15 - doze keeps clock only if enabled, slow
// RULE16 - reset holds off, outputs tri-stated, then idle
// RULE17 - indicators high when true, else low
module msb_sideband (
  input wire logic clk,
  input wire logic rstn,
  // pins from the host, asynchronous to clk
  input wire logic modem_reset_n,
  input wire logic wake_attention_n,
  input wire logic radio_sequence_enable,
  input wire logic host_select_out_n,
  input wire logic modem_serial_clock,
  // configuration bits held by the modem register file
  input wire logic [2:0] clk_sel,
  input wire logic doze_clk_en,
  input wire logic gpio_alt_en,
  input wire logic miso_hiz_en,
  input wire logic [1:0] gpio_dir,
  input wire logic [1:0] gpio_out,
  // events and data from the modem core, same clock
  input wire logic doze_req,
  input wire logic hibernate_req,
  input wire logic crc_valid,
  input wire logic irq_req,
  input wire logic read_bit,
  // status to the modem core
  output logic [2:0] mode,
  output logic read_bit_take,
  // pins toward the host
  output logic modem_clock_out,
  output logic crc_valid_pin_o,
  output logic crc_valid_pin_oe,
  output logic out_of_idle_pin_o,
  output logic out_of_idle_pin_oe,
  output logic miso_o,
  output logic miso_oe,
  output logic irq_n_o,
  output logic irq_n_oe
);

  typedef struct packed {
    logic [1:0] rst_sync;
    logic [1:0] wake_attention_n_sync;
    logic [1:0] rxen_sync;
    logic [1:0] sel_sync;
    logic [1:0] sck_sync;
    logic sck_prev;
    msb_pkg::msb_mode_t st;
    logic miso;
    logic irq_n;
    logic [1:0] pin_val;
    logic [1:0] pin_oe;
    logic miso_oe;
    logic irq_oe;
  } msb_state_t;

  msb_state_t s_q;
  msb_state_t s_d;
  logic sck_fall;
  logic selected;
  logic powered;

  msb_clk_if cif ();

  ////////////////////////////////////////////////////////////////////////////
  // only the second stage of each synchroniser is read by logic
  assign selected = !s_q.sel_sync[1];
  assign sck_fall = s_q.sck_prev && !s_q.sck_sync[1];
  assign powered = (s_q.st != msb_pkg::ST_OFF);

  // mode sequencing, pin drive and serial data-out in one next-state block
  always_comb begin
    s_d = s_q;
    s_d.rst_sync = {s_q.rst_sync[0], modem_reset_n};
    s_d.wake_attention_n_sync = {s_q.wake_attention_n_sync[0], wake_attention_n};
    s_d.rxen_sync = {s_q.rxen_sync[0], radio_sequence_enable};
    s_d.sel_sync = {s_q.sel_sync[0], host_select_out_n};
    s_d.sck_sync = {s_q.sck_sync[0], modem_serial_clock};
    s_d.sck_prev = s_q.sck_sync[1];
    read_bit_take = 1'b0;
    case (s_q.st)
      msb_pkg::ST_OFF: begin
        if (s_q.rst_sync[1]) begin
          s_d.st = msb_pkg::ST_IDLE; // RULE16
        end
      end
      msb_pkg::ST_IDLE: begin
        if (s_q.rxen_sync[1]) begin
          s_d.st = msb_pkg::ST_ACTIVE;
        end else if (hibernate_req) begin
          s_d.st = msb_pkg::ST_HIBER;
        end else if (doze_req) begin
          s_d.st = msb_pkg::ST_DOZE;
        end
      end
      msb_pkg::ST_DOZE, msb_pkg::ST_HIBER: begin
        if (!s_q.wake_attention_n_sync[1]) begin
          s_d.st = msb_pkg::ST_IDLE; // RULE6
        end
      end
      msb_pkg::ST_ACTIVE: begin
        // the sequence runs for as long as the host holds the enable
        if (!s_q.rxen_sync[1]) begin
          s_d.st = msb_pkg::ST_IDLE;
        end
      end
      default: begin
        s_d.st = msb_pkg::ST_OFF;
      end
    endcase
    // reset pin overrides every mode; in off every pin with an output enable floats and the clock output is held low
    if (!s_q.rst_sync[1]) begin
      s_d.st = msb_pkg::ST_OFF; // RULE16
    end
    // read data shifts out on the falling serial clock while selected
    if (selected && sck_fall && s_q.st != msb_pkg::ST_OFF) begin
      s_d.miso = read_bit; // RULE13
      read_bit_take = 1'b1;
    end else if (!selected) begin
      s_d.miso = 1'b0; // RULE8
    end
    // deselected data-out floats while miso_hiz_en is set, otherwise it is driven low
    s_d.miso_oe = (s_d.st != msb_pkg::ST_OFF) && (selected || !miso_hiz_en); // RULE8
    s_d.irq_n = !irq_req; // RULE11
    s_d.irq_oe = (s_d.st != msb_pkg::ST_OFF);
    // index 0 is the out-of-idle pin, index 1 the CRC-valid pin
    if (s_d.st == msb_pkg::ST_OFF) begin
      s_d.pin_oe = 2'h0; // RULE4
      s_d.pin_val = 2'h0;
    end else if (gpio_alt_en) begin
      s_d.pin_oe = 2'h3;
      s_d.pin_val[1] = crc_valid; // RULE2 RULE17
      s_d.pin_val[0] = (s_d.st == msb_pkg::ST_ACTIVE); // RULE3 RULE17
    end else begin
      // plain general-purpose use; direction bits come up as inputs
      s_d.pin_oe = gpio_dir; // RULE4
      s_d.pin_val = gpio_out;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '{rst_sync: 2'h0, wake_attention_n_sync: 2'h3, rxen_sync: 2'h0, sel_sync: 2'h3,
               sck_sync: 2'h0, sck_prev: 1'b0, st: msb_pkg::ST_OFF, miso: 1'b0,
               irq_n: 1'b1, pin_val: 2'h0, pin_oe: 2'h0, miso_oe: 1'b0, irq_oe: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock output: runs in idle and active; in doze only when enabled and slow
  assign cif.sel = clk_sel;
  assign cif.run = (s_q.st == msb_pkg::ST_IDLE) || (s_q.st == msb_pkg::ST_ACTIVE) ||
                   ((s_q.st == msb_pkg::ST_DOZE) && doze_clk_en && (clk_sel >= msb_pkg::SEL_1M)); // RULE15

  msb_clkgen #(
    .ACC_W(msb_pkg::ACC_W)
  ) u_clkgen (
    .clk(clk),
    .rstn(rstn),
    .cif(cif.gen)
  );

  // output pins straight from flops
  assign mode = s_q.st;
  assign modem_clock_out = cif.clk_out; // RULE1
  assign crc_valid_pin_o = s_q.pin_val[1];
  assign crc_valid_pin_oe = s_q.pin_oe[1];
  assign out_of_idle_pin_o = s_q.pin_val[0];
  assign out_of_idle_pin_oe = s_q.pin_oe[0];
  assign miso_o = s_q.miso;
  assign miso_oe = s_q.miso_oe;
  assign irq_n_o = s_q.irq_n;
  assign irq_n_oe = s_q.irq_oe;

  ////////////////////////////////////////////////////////////////////////////
  // checks on the pin behaviour
  chk_off_all_float: assert property (@(posedge clk) disable iff (!rstn) // RULE16
    (s_q.st == msb_pkg::ST_OFF) |-> !(miso_oe || irq_n_oe || crc_valid_pin_oe || out_of_idle_pin_oe))
    else $error("output driven while off");

  chk_reset_to_idle: assert property (@(posedge clk) disable iff (!rstn) // RULE16
    (s_q.st == msb_pkg::ST_OFF) && s_q.rst_sync[1] |=> (s_q.st == msb_pkg::ST_IDLE))
    else $error("no move from off to idle at reset release");

  chk_wake_to_idle: assert property (@(posedge clk) disable iff (!rstn) // RULE6
    ((s_q.st == msb_pkg::ST_DOZE) || (s_q.st == msb_pkg::ST_HIBER)) && !s_q.wake_attention_n_sync[1] && s_q.rst_sync[1]
    |=> (s_q.st == msb_pkg::ST_IDLE)) else $error("attention did not wake to idle");

  // three samples of a low pin cover both synchroniser stages and the mode step
  chk_wake_attention_n_pin_wake: assert property (@(posedge clk) disable iff (!rstn) // RULE6
    ((s_q.st == msb_pkg::ST_HIBER) && !wake_attention_n && modem_reset_n) [*3]
    |=> (s_q.st == msb_pkg::ST_IDLE)) else $error("held attention pin did not wake");

  chk_miso_float: assert property (@(posedge clk) disable iff (!rstn) // RULE8
    $past(!selected && miso_hiz_en) |-> !miso_oe) else $error("data-out driven while deselected");

  chk_miso_drive_low: assert property (@(posedge clk) disable iff (!rstn) // RULE8
    $past(!selected && !miso_hiz_en) && powered |-> miso_oe && !miso_o)
    else $error("data-out not driven low while deselected");

  chk_crc_pin_level: assert property (@(posedge clk) disable iff (!rstn) // RULE2
    $past(gpio_alt_en) && powered |-> crc_valid_pin_oe && (crc_valid_pin_o == $past(crc_valid)))
    else $error("crc indicator wrong");

  chk_ooi_pin_level: assert property (@(posedge clk) disable iff (!rstn) // RULE3
    $past(gpio_alt_en) && powered |-> out_of_idle_pin_oe && (out_of_idle_pin_o == (s_q.st == msb_pkg::ST_ACTIVE)))
    else $error("out-of-idle indicator wrong");

  chk_gpio_input: assert property (@(posedge clk) disable iff (!rstn) // RULE4
    $past(!gpio_alt_en && gpio_dir == 2'h0) |-> !crc_valid_pin_oe && !out_of_idle_pin_oe)
    else $error("pin driven while configured as input");

  chk_irq_follows: assert property (@(posedge clk) disable iff (!rstn) // RULE11
    powered |-> (irq_n_o == !$past(irq_req)) && irq_n_oe) else $error("interrupt output wrong");

  // watches the pin itself, one edge after the gate closed, not the gate term
  chk_doze_clk_gate: assert property (@(posedge clk) disable iff (!rstn) // RULE15
    $past((s_q.st == msb_pkg::ST_DOZE) && !(doze_clk_en && clk_sel >= msb_pkg::SEL_1M)) |-> !modem_clock_out)
    else $error("clock output running in doze without enable");

  cov_wake_from_doze: cover property (@(posedge clk) disable iff (!rstn)
    (s_q.st == msb_pkg::ST_DOZE) ##1 (s_q.st == msb_pkg::ST_IDLE));
  cov_active_cycle: cover property (@(posedge clk) disable iff (!rstn)
    (s_q.st == msb_pkg::ST_IDLE) ##1 (s_q.st == msb_pkg::ST_ACTIVE) ##[1:200] (s_q.st == msb_pkg::ST_IDLE));
  cov_read_bit: cover property (@(posedge clk) disable iff (!rstn) read_bit_take);
  cov_hiber_wake: cover property (@(posedge clk) disable iff (!rstn)
    (s_q.st == msb_pkg::ST_HIBER) ##1 (s_q.st == msb_pkg::ST_IDLE));

endmodule : msb_sideband

// File: tb/msb_host_model.sv
// host side model: drives the modem control pins and the serial link
module msb_host_model (
  input wire logic clk,
  output logic modem_reset_n,
  output logic wake_attention_n,
  output logic radio_sequence_enable,
  output logic host_select_out_n,
  output logic modem_serial_clock
);
  timeunit 1ns;
  timeprecision 1ps;
  // every pin is driven from time zero and never floats, modem held in reset
  initial begin
    modem_reset_n = 1'b0;
    wake_attention_n = 1'b1;
    radio_sequence_enable = 1'b0;
    host_select_out_n = 1'b1;
    modem_serial_clock = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // reset, attention and radio enable change together after a falling edge
  task automatic drive(input logic rst_n, input logic att_n, input logic ren);
    @(negedge clk);
    modem_reset_n = rst_n;
    wake_attention_n = att_n;
    radio_sequence_enable = ren;
  endtask : drive
  // one select-framed burst; 200 ns serial period stays under the 8 MHz ceiling
  // odd start offset keeps the serial clock out of phase with the block clock
  task automatic frame(input int bits);
    #37;
    host_select_out_n = 1'b0;
    for (int i = 0; i < bits; i++) begin
      #100 modem_serial_clock = 1'b1;
      #100 modem_serial_clock = 1'b0;
    end
    #100 host_select_out_n = 1'b1;
  endtask : frame
endmodule : msb_host_model

// File: tb/tb_top.sv
// self-checking bench for the modem sideband pin block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, modem_reset_n, wake_attention_n, radio_sequence_enable, host_select_out_n, modem_serial_clock;
  logic [2:0] clk_sel, mode;
  logic [1:0] gpio_dir, gpio_out;
  logic doze_clk_en, gpio_alt_en, miso_hiz_en, doze_req, hibernate_req, crc_valid, irq_req, read_bit;
  logic read_bit_take, modem_clock_out, crc_valid_pin_o, crc_valid_pin_oe, out_of_idle_pin_o, out_of_idle_pin_oe;
  logic miso_o, miso_oe, irq_n_o, irq_n_oe, pend, pbit, last_clk;
  logic [31:0] r;
  logic [31:0] seed = 32'h000066e4;
  int bad_count, num_checks, edges, hits, takes;

  msb_sideband dut (.clk(clk), .rstn(rstn), .modem_reset_n(modem_reset_n), .wake_attention_n(wake_attention_n),
    .radio_sequence_enable(radio_sequence_enable), .host_select_out_n(host_select_out_n),
    .modem_serial_clock(modem_serial_clock), .clk_sel(clk_sel), .doze_clk_en(doze_clk_en),
    .gpio_alt_en(gpio_alt_en), .miso_hiz_en(miso_hiz_en), .gpio_dir(gpio_dir), .gpio_out(gpio_out),
    .doze_req(doze_req), .hibernate_req(hibernate_req), .crc_valid(crc_valid), .irq_req(irq_req),
    .read_bit(read_bit), .mode(mode), .read_bit_take(read_bit_take), .modem_clock_out(modem_clock_out),
    .crc_valid_pin_o(crc_valid_pin_o), .crc_valid_pin_oe(crc_valid_pin_oe), .out_of_idle_pin_o(out_of_idle_pin_o),
    .out_of_idle_pin_oe(out_of_idle_pin_oe), .miso_o(miso_o), .miso_oe(miso_oe), .irq_n_o(irq_n_o),
    .irq_n_oe(irq_n_oe));
  msb_host_model host (.clk(clk), .modem_reset_n(modem_reset_n), .wake_attention_n(wake_attention_n),
    .radio_sequence_enable(radio_sequence_enable), .host_select_out_n(host_select_out_n),
    .modem_serial_clock(modem_serial_clock));

  ////////////////////////////////////////////////////////////////////////////
  // 25 ns clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic done(input string n);
    $display("test %s done", n);
  endtask : done
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  // bounded wait, the mode machine answers within a few edges of its cause
  task automatic wait_mode(input msb_pkg::msb_mode_t m, input string w);
    for (int i = 0; i < 20 && mode !== m; i++) @(negedge clk);
    chk(mode === m, w);
  endtask : wait_mode
  task automatic pulse(input bit hib);
    @(negedge clk);
    if (hib) hibernate_req = 1'b1;
    else doze_req = 1'b1;
    @(negedge clk);
    doze_req = 1'b0;
    hibernate_req = 1'b0;
  endtask : pulse
  // window opens and closes on the rising edge so the negedge counter never races it
  task automatic cnt_edges(input int n);
    repeat (20) @(negedge clk);
    @(posedge clk);
    edges = 0;
    repeat (n) @(posedge clk);
    hits = edges;
    @(negedge clk);
  endtask : cnt_edges
  function automatic real exp_edges(input int s);
    return real'(s < 5 ? 1000 : 8000) * msb_pkg::XTAL_HZ / (real'(msb_pkg::MODEM_CLOCK_OUT_DIV[s]) * msb_pkg::CLK_HZ);
  endfunction : exp_edges

  ////////////////////////////////////////////////////////////////////////////
  // read bits fed at random; each taken bit must show on data-out one edge later
  // also counts rising edges of the clock output, sampled once per cycle
  always @(negedge clk) begin
    if (pend === 1'b1) chk(miso_o === pbit && miso_oe === 1'b1, "serial read bit");
    pend = read_bit_take;
    if (read_bit_take === 1'b1) takes++;
    read_bit = 1'(xs());
    pbit = read_bit;
    if (modem_clock_out === 1'b1 && last_clk === 1'b0) edges++;
    last_clk = modem_clock_out;
  end

  // main sequence
  initial begin
    rstn = 1'b0;
    {doze_clk_en, gpio_alt_en, doze_req, hibernate_req, crc_valid, irq_req, read_bit, pend} = '0;
    {clk_sel, miso_hiz_en, gpio_dir, gpio_out} = {msb_pkg::CLK_SEL_RST, 1'b1, 2'h0, 2'h0};
    repeat (3) @(negedge clk);
    chk(mode === msb_pkg::ST_OFF && {crc_valid_pin_oe, out_of_idle_pin_oe, miso_oe, irq_n_oe} === 4'h0, "off");
    rstn = 1'b1;
    host.drive(1'b1, 1'b1, 1'b0);
    wait_mode(msb_pkg::ST_IDLE, "idle after reset");
    chk(crc_valid_pin_oe === 1'b0 && out_of_idle_pin_oe === 1'b0, "pins are inputs");
    done("reset");
    for (int s = 0; s < 8; s++) begin
      clk_sel = 3'(s);
      cnt_edges(s < 5 ? 1000 : 8000);
      chk(hits > exp_edges(s) - 2.0 && hits < exp_edges(s) + 2.0, "rate");
    end
    done("clock output");
    gpio_alt_en = 1'b1;
    repeat (60) begin
      @(negedge clk);
      chk(crc_valid_pin_oe === 1'b1 && crc_valid_pin_o === crc_valid, "crc indicator");
      chk(irq_n_oe === 1'b1 && irq_n_o === ~irq_req, "interrupt");
      r = xs();
      crc_valid = r[0];
      irq_req = r[1];
    end
    host.drive(1'b1, 1'b1, 1'b1);
    wait_mode(msb_pkg::ST_ACTIVE, "active");
    chk(out_of_idle_pin_oe === 1'b1 && out_of_idle_pin_o === 1'b1, "out of idle high");
    host.drive(1'b1, 1'b1, 1'b0);
    wait_mode(msb_pkg::ST_IDLE, "back to idle");
    chk(out_of_idle_pin_o === 1'b0, "out of idle low");
    {gpio_alt_en, gpio_dir, gpio_out} = {1'b0, 2'h3, 2'h2};
    repeat (2) @(negedge clk);
    chk({crc_valid_pin_oe, out_of_idle_pin_oe, crc_valid_pin_o, out_of_idle_pin_o} === 4'he, "plain outputs");
    done("indicators");
    takes = 0;
    host.frame(16);
    repeat (4) @(negedge clk);
    chk(takes == 16, "one bit per serial fall");
    chk(miso_oe === 1'b0, "data-out released");
    miso_hiz_en = 1'b0;
    repeat (2) @(negedge clk);
    chk(miso_oe === 1'b1 && miso_o === 1'b0, "data-out parked low");
    done("serial");
    clk_sel = msb_pkg::SEL_1M;
    pulse(1'b0);
    wait_mode(msb_pkg::ST_DOZE, "doze");
    cnt_edges(200);
    chk(hits == 0, "doze clock stopped");
    doze_clk_en = 1'b1;
    cnt_edges(200);
    chk(hits > 3, "doze clock kept");
    clk_sel = msb_pkg::SEL_2M;
    cnt_edges(200);
    chk(hits == 0, "fast clock stopped in doze");
    host.drive(1'b1, 1'b0, 1'b0);
    wait_mode(msb_pkg::ST_IDLE, "wake from doze");
    host.drive(1'b1, 1'b1, 1'b0);
    pulse(1'b1);
    wait_mode(msb_pkg::ST_HIBER, "hibernate");
    host.drive(1'b1, 1'b0, 1'b0);
    wait_mode(msb_pkg::ST_IDLE, "wake from hibernate");
    done("low power");
    host.drive(1'b0, 1'b1, 1'b0);
    wait_mode(msb_pkg::ST_OFF, "host reset");
    repeat (2) @(negedge clk);
    chk({crc_valid_pin_oe, out_of_idle_pin_oe, miso_oe, irq_n_oe} === 4'h0, "outputs released");
    done("host reset");
    stop_test();
  end
  // watchdog well past the expected run of about three quarters of a millisecond
  initial begin
    #2_000_000;
    bad_count++;
    stop_test();
  end
endmodule : tb_top
